/* File: inc/fan_params.svh */
// constants for the fan pwm and spin-up configuration block
// assumes a 100 MHz aclk and an AXI4-Lite master that addresses index * 4
`ifndef FAN_PARAMS_SVH
`define FAN_PARAMS_SVH

// register indices; byte address is index * 4
`define IDX_CFG 8'h03
`define IDX_CFG_MIRROR 8'h09
`define IDX_PWM_CFG 8'h4a
`define IDX_SPIN_CFG 8'h4b
`define IDX_DUTY 8'h4c
`define IDX_FREQ 8'h4d
`define IDX_LUT_HI 4'h5

// reset values
`define RST_CFG 8'h00
`define RST_PWM_CFG 6'h20
`define RST_SPIN_CFG 6'h3f
`define RST_DUTY 6'h00
`define RST_FREQ 5'h17
`define RST_LUT_TEMP 8'h7f
`define RST_LUT_PWM 8'h3f

// field masks of the lookup table entries
`define LUT_TEMP_MASK 8'h7f
`define LUT_PWM_MASK 8'h3f

// spin-up duty levels on the 6-bit duty scale
`define DUTY_OFF 6'h00
`define DUTY_HALF 6'h20
`define DUTY_3Q 6'h30
`define DUTY_FULL 6'h3f

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timing
`define CLK_FREQ_HZ 100000000
`define PWM_FAST_HZ 360000
`define PWM_SLOW_HZ 1400
`define PWM_FAST_DIV (`CLK_FREQ_HZ / `PWM_FAST_HZ)
`define PWM_SLOW_DIV (`CLK_FREQ_HZ / `PWM_SLOW_HZ)
`define SPINUP_BASE_MS 50
`define SPINUP_BASE_CYCLES (`SPINUP_BASE_MS * (`CLK_FREQ_HZ / 1000))

`endif

/* File: inc/fan_pkg.sv */
// types shared by the fan pwm and spin-up files
// assumes nothing of its surroundings
package fan_pkg;

  // low six bits of the pwm and tach configuration register
  typedef struct packed {
    logic pwm_prog;
    logic polarity;
    logic clk_sel;
    logic rsvd;
    logic [1:0] tach_mode;
  } fan_cfg_t;

  // low six bits of the spin-up configuration register
  typedef struct packed {
    logic fast;
    logic [1:0] duty_code;
    logic [2:0] time_code;
  } spin_cfg_t;

  typedef enum logic [0:0] {
    SPIN_IDLE,
    SPIN_RUN
  } spin_state_t;

endpackage

/* File: verilog/fan_spinup.sv */
// spin-up sequencer: forces a start-up duty for a programmed time
// assumes the commanded duty and configuration are synchronous to aclk
`timescale 1ns/1ns
`include "fan_params.svh"

module fan_spinup #(
  parameter int unsigned BASE_CYCLES = `SPINUP_BASE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration and commanded duty
  input fan_pkg::spin_cfg_t cfg,
  input wire logic [5:0] cmd_duty,
  input wire logic tach_reached,
  // spin-up state
  output logic active,
  output logic [5:0] spin_duty
);
  import fan_pkg::*;

  if (BASE_CYCLES < 1 || BASE_CYCLES > 32'h0200_0000) begin : g_chk
    $error("spin-up base period out of range");
  end

  spin_state_t state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [5:0] prev_duty_q;
  logic [5:0] duty_q, duty_d;

  wire rising = (prev_duty_q == `DUTY_OFF) && (cmd_duty != `DUTY_OFF);
  wire bypass = (cfg.time_code == 3'h0) ||
                (cfg.duty_code == 2'h0 && !cfg.fast);
  wire [31:0] length = BASE_CYCLES << (cfg.time_code - 3'h1);
  wire [5:0] level = cfg.fast ? `DUTY_FULL :
                     (cfg.duty_code == 2'h1) ? `DUTY_HALF :
                     (cfg.duty_code == 2'h2) ? `DUTY_3Q : `DUTY_FULL;
  wire expired = (timer_q == 32'h1);
  wire tach_end = cfg.fast && tach_reached;

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    duty_d = duty_q;
    case (state_q)
      SPIN_IDLE: begin
        if (rising && !bypass) begin
          state_d = SPIN_RUN;
          timer_d = length;
          duty_d = level;
        end
      end
      SPIN_RUN: begin
        // timeout ends spin-up; in fast mode the tach target ends it too, whichever comes first
        if (expired || tach_end) begin
          state_d = SPIN_IDLE;
          timer_d = 32'h0;
        end else begin
          timer_d = timer_q - 32'h1;
        end
      end
      default: begin
        state_d = SPIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SPIN_IDLE;
      timer_q <= 32'h0;
      duty_q <= `DUTY_OFF;
      prev_duty_q <= `DUTY_OFF;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      duty_q <= duty_d;
      prev_duty_q <= cmd_duty;
    end
  end

  assign active = (state_q == SPIN_RUN);
  assign spin_duty = duty_q;
endmodule

/* File: verilog/fan_pwm_gen.sv */
// pwm waveform generator with open-drain output and polarity select
// assumes duty and frequency settings are synchronous to aclk
`timescale 1ns/1ns
`include "fan_params.svh"

module fan_pwm_gen #(
  parameter int unsigned FAST_DIV = `PWM_FAST_DIV,
  parameter int unsigned SLOW_DIV = `PWM_SLOW_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic clk_sel,
  input wire logic polarity,
  input wire logic [4:0] freq_n,
  input wire logic [5:0] duty,
  // open-drain pin
  output logic pwm_o,
  output logic pwm_oe
);
  if (FAST_DIV < 1 || SLOW_DIV < 1) begin : g_chk
    $error("pwm clock dividers must be at least one");
  end

  logic [31:0] pre_q;
  logic [5:0] cnt_q;
  logic oe_q;

  // master pwm clock as a one-cycle tick
  wire [31:0] div = clk_sel ? SLOW_DIV : FAST_DIV;
  wire tick = (pre_q >= div - 32'h1);
  // period is 2n master ticks, n of zero counts as one
  wire [4:0] n_eff = (freq_n == 5'h0) ? 5'h1 : freq_n;
  wire [5:0] period = {n_eff, 1'b0};
  wire period_end = (cnt_q >= period - 6'h1);
  // full scale 63 means always on
  wire [11:0] lhs = 12'(cnt_q) * 12'h03f;
  wire [11:0] rhs = 12'(duty) * 12'(period);
  wire fan_on = (lhs < rhs);
  // pulling low means fan off unless the polarity is inverted
  wire oe_d = polarity ? fan_on : !fan_on;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 32'h0;
      cnt_q <= 6'h0;
      oe_q <= 1'b0;
    end else begin
      pre_q <= tick ? 32'h0 : pre_q + 32'h1;
      if (tick) begin
        cnt_q <= period_end ? 6'h0 : cnt_q + 6'h1;
      end
      oe_q <= oe_d;
    end
  end

  assign pwm_o = 1'b0;
  assign pwm_oe = oe_q;
endmodule

/* File: verilog/fan_pwm_spinup_config.sv */
// fan pwm and spin-up configuration with an AXI4-Lite register slave
// assumes a 100 MHz aclk, synchronous active-low reset, and a tach block
// outside that reports when the fan reaches its target speed
`timescale 1ns/1ns
`include "fan_params.svh"

// Functional notes
// - Duty bit clear: duty comes from table, duty and table writes ignored.
// - Duty bit set: duty and table writable, duty write acts at once.
// - Polarity clear pulls pin low for fan off; set inverts that sense.
// - Clock select picks 360 kHz master clock at 0, 1.4 kHz at 1.
// - Tach mode 00 is traditional monitoring, slow fans may misread.
// - Tach mode 01 is traditional monitoring reporting FFFF when too slow.
// - Modes 10 and 11 enable smart tach, FFFF when too slow.
// - With the 360 kHz clock the tach runs in mode 00 always.
// - Spin-up configuration bits 7:6 read as zero.
// - Fast spin-up drives full duty until timeout or tach target.
// - Fast spin-up ignores the spin-up duty field, always full on.
// - Without fast spin-up, programmed duty and time fields are used.
// - Spin-up time code 000 bypasses spin-up entirely.
// - Duty codes: 00 bypass unless fast, 01 half, 10 3/4, 11 full.
// - Mirror addresses reach one and the same physical register.
// - Duty register reads zero while spin-up is in progress.
// - Pwm frequency is master clock over 2n, n of zero taken as one.
module fan_pwm_spinup_config #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned FAST_DIV = `PWM_FAST_DIV,
  parameter int unsigned SLOW_DIV = `PWM_SLOW_DIV,
  parameter int unsigned SPIN_BASE = `SPINUP_BASE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // temperature and tach status from the rest of the device
  input wire logic [7:0] remote_temp,
  input wire logic tach_reached,
  // fan pin, open drain
  output logic pwm_o,
  output logic pwm_oe,
  // tach block control
  output logic [1:0] tach_mode,
  output logic tach_report_ffff,
  output logic smart_tach_en,
  output logic tach_pin_sel
);
  import fan_pkg::*;

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
    $error("address width must be 10 to 32 bits");
  end

  // top bit flags an address above the decoded window
  function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] a);
    logic hi;
    hi = 1'b0;
    for (int i = 10; i < ADDR_W; i++) begin
      hi = hi | a[i];
    end
    return {hi, a[9:2]};
  endfunction

  function automatic logic idx_is(input logic [8:0] idx, input logic [7:0] reg_idx);
    return idx == {1'b0, reg_idx};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  fan_cfg_t pwm_cfg_q;
  spin_cfg_t spin_cfg_q;
  logic [7:0] cfg_q;
  logic [5:0] duty_q;
  logic [4:0] freq_q;
  logic [7:0] lut_q [16];

  // write channel state; a low ready means the item is held
  logic awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // read channel state
  logic arready_q, rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // tach control flops
  logic [1:0] tach_mode_q;
  logic ffff_q, smart_q, pin_sel_q;

  logic spin_active;
  logic [5:0] spin_duty;
  logic [5:0] lut_duty;

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  wire do_wr = !awready_q && !wready_q && !bvalid_q;
  wire [8:0] wr_idx = reg_index(awaddr_q);
  wire wr_lane = do_wr && wstrb_q[0];
  wire [7:0] wr_byte = wdata_q[7:0];
  wire wr_is_cfg = idx_is(wr_idx, `IDX_CFG) || idx_is(wr_idx, `IDX_CFG_MIRROR);
  wire wr_is_pwm = idx_is(wr_idx, `IDX_PWM_CFG);
  wire wr_is_spin = idx_is(wr_idx, `IDX_SPIN_CFG);
  wire wr_is_duty = idx_is(wr_idx, `IDX_DUTY);
  wire wr_is_freq = idx_is(wr_idx, `IDX_FREQ);
  wire wr_is_lut = !wr_idx[8] && (wr_idx[7:4] == `IDX_LUT_HI);
  wire wr_hit = wr_is_cfg || wr_is_pwm || wr_is_spin || wr_is_duty || wr_is_freq ||
                wr_is_lut;
  // duty and table writes are accepted but dropped unless direct mode is on
  wire duty_we = wr_lane && wr_is_duty && pwm_cfg_q.pwm_prog;
  wire lut_we = wr_lane && wr_is_lut && pwm_cfg_q.pwm_prog;
  // odd entries hold duty, even ones temperature
  wire [7:0] lut_mask = wr_idx[0] ? `LUT_PWM_MASK : `LUT_TEMP_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  wire [8:0] rd_idx = reg_index(s_axi_araddr);
  wire rd_is_cfg = idx_is(rd_idx, `IDX_CFG) || idx_is(rd_idx, `IDX_CFG_MIRROR);
  wire rd_is_pwm = idx_is(rd_idx, `IDX_PWM_CFG);
  wire rd_is_spin = idx_is(rd_idx, `IDX_SPIN_CFG);
  wire rd_is_duty = idx_is(rd_idx, `IDX_DUTY);
  wire rd_is_freq = idx_is(rd_idx, `IDX_FREQ);
  wire rd_is_lut = !rd_idx[8] && (rd_idx[7:4] == `IDX_LUT_HI);
  wire rd_hit = rd_is_cfg || rd_is_pwm || rd_is_spin || rd_is_duty || rd_is_freq ||
                rd_is_lut;
  wire [5:0] duty_view = spin_active ? `DUTY_OFF : duty_q;
  wire [7:0] rd_byte = rd_is_cfg ? cfg_q :
                       rd_is_pwm ? {2'h0, pwm_cfg_q} :
                       rd_is_spin ? {2'h0, spin_cfg_q} :
                       rd_is_duty ? {2'h0, duty_view} :
                       rd_is_freq ? {3'h0, freq_q} :
                       rd_is_lut ? lut_q[rd_idx[3:0]] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // lookup table: the last pair whose temperature is exceeded sets the duty

  always_comb begin
    lut_duty = `DUTY_OFF;
    for (int i = 0; i < 8; i++) begin
      if (!remote_temp[7] && (remote_temp[6:0] > lut_q[2 * i][6:0])) begin
        lut_duty = lut_q[2 * i + 1][5:0];
      end
    end
  end

  // effective tach mode: the fast master clock forces traditional monitoring
  wire [1:0] tach_mode_d = pwm_cfg_q.clk_sel ? pwm_cfg_q.tach_mode : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      // both channels reopen only once the response is taken
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channels: data one cycle after the address is taken

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q <= {24'h0, rd_byte};
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `RST_CFG;
      pwm_cfg_q <= fan_cfg_t'(`RST_PWM_CFG);
      spin_cfg_q <= spin_cfg_t'(`RST_SPIN_CFG);
      freq_q <= `RST_FREQ;
    end else begin
      if (wr_lane && wr_is_cfg) begin
        cfg_q <= wr_byte;
      end
      if (wr_lane && wr_is_pwm) begin
        pwm_cfg_q <= fan_cfg_t'(wr_byte[5:0]);
      end
      if (wr_lane && wr_is_spin) begin
        spin_cfg_q <= spin_cfg_t'(wr_byte[5:0]);
      end
      if (wr_lane && wr_is_freq) begin
        freq_q <= wr_byte[4:0];
      end
    end
  end

  // duty follows the table in table mode, else holds the last written value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_q <= `RST_DUTY;
    end else if (!pwm_cfg_q.pwm_prog) begin
      duty_q <= lut_duty;
    end else if (duty_we) begin
      duty_q <= wr_byte[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        lut_q[i] <= i[0] ? `RST_LUT_PWM : `RST_LUT_TEMP;
      end
    end else if (lut_we) begin
      lut_q[wr_idx[3:0]] <= wr_byte & lut_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tach_mode_q <= 2'h0;
      ffff_q <= 1'b0;
      smart_q <= 1'b0;
      pin_sel_q <= 1'b0;
    end else begin
      tach_mode_q <= tach_mode_d;
      ffff_q <= (tach_mode_d != 2'h0);
      smart_q <= tach_mode_d[1];
      pin_sel_q <= cfg_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spin-up and waveform

  fan_spinup #(
    .BASE_CYCLES(SPIN_BASE)
  ) u_spinup (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(spin_cfg_q),
    .cmd_duty(duty_q),
    .tach_reached(tach_reached),
    .active(spin_active),
    .spin_duty(spin_duty)
  );

  wire [5:0] out_duty = spin_active ? spin_duty : duty_q;

  fan_pwm_gen #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)
  ) u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(pwm_cfg_q.clk_sel),
    .polarity(pwm_cfg_q.polarity),
    .freq_n(freq_q),
    .duty(out_duty),
    .pwm_o(pwm_o),
    .pwm_oe(pwm_oe)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign tach_mode = tach_mode_q;
  assign tach_report_ffff = ffff_q;
  assign smart_tach_en = smart_q;
  assign tach_pin_sel = pin_sel_q;
endmodule

/* File: verification/fan_cfg_chk.sv */
// port assertions for the fan pwm and spin-up register block
// assumes it is bound into the block and shares its ADDR_W
`timescale 1ns/1ns
module fan_cfg_chk #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fan pin and tach control
  input wire logic pwm_o,
  input wire logic [1:0] tach_mode,
  input wire logic tach_report_ffff,
  input wire logic smart_tach_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  pin_low_a:
    assert property (pwm_o == 1'b0) else $error("pwm pin data not low");
  ffff_flag_a:
    assert property (tach_report_ffff == (tach_mode != 2'h0)) else $error("ffff flag wrong");
  smart_flag_a:
    assert property (smart_tach_en == tach_mode[1]) else $error("smart tach flag wrong");
  rdata_top_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata top set");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
  bad_read_a:
    assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr >> 10) != '0
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  read_free_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read slot not freed");
  write_free_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write slot not freed");
endmodule

bind fan_pwm_spinup_config fan_cfg_chk #(.ADDR_W(ADDR_W)) u_fan_cfg_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pwm_o(pwm_o), .tach_mode(tach_mode), .tach_report_ffff(tach_report_ffff),
  .smart_tach_en(smart_tach_en)
);

/* File: verification/fan_model.sv */
// fan behind the open-drain pin, with a tach that reports target speed
// assumes the bench tells it the programmed polarity
`timescale 1ns/1ns
module fan_model #(
  parameter int unsigned TARGET = 30
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and polarity
  input wire logic pwm_o,
  input wire logic pwm_oe,
  input wire logic polarity,
  // fan state
  output logic fan_on,
  output logic tach_reached
);
  logic pin;
  int unsigned run_q;
  // released pin floats up through the pull-up
  assign pin = pwm_oe ? pwm_o : 1'b1;
  assign fan_on = polarity ? !pin : pin;
  // a real fan needs a run of full power before it shows speed
  assign tach_reached = run_q >= TARGET;
  always_ff @(posedge aclk) begin
    if (!aresetn || !fan_on) begin
      run_q <= 0;
    end else if (run_q < TARGET) begin
      run_q <= run_q + 1;
    end
  end
endmodule

/* File: verification/tb_fan_pwm_spinup_config.sv */
// self-checking bench for the fan pwm and spin-up register block
// assumes the design include path and the fan model beside the block
`timescale 1ns/1ns
`include "fan_params.svh"
module tb_fan_pwm_spinup_config;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tach_reached, pwm_o, pwm_oe;
  logic ffff, smart, pin_sel, pol, fan_on;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, tach_mode;
  logic [7:0] remote_temp;
  int n_errors = 0;
  int compares = 0;
  // spin configs, wait after spin-up starts, duty read then
  logic [7:0] sc [4] = '{8'h1a, 8'h1a, 8'h1f, 8'h27};
  int sw [4] = '{15, 50, 100, 100};
  logic [7:0] se [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  logic [7:0] bc [3] = '{8'h18, 8'h01, 8'h38};

  fan_pwm_spinup_config #(.FAST_DIV(2), .SLOW_DIV(8), .SPIN_BASE(20))
  u_fan_pwm_spinup_config (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remote_temp(remote_temp), .tach_reached(tach_reached), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .tach_mode(tach_mode), .tach_report_ffff(ffff), .smart_tach_en(smart),
    .tach_pin_sel(pin_sel)
  );
  fan_model u_fan_model (.aclk(aclk), .aresetn(aresetn), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .polarity(pol), .fan_on(fan_on), .tach_reached(tach_reached));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang;
    n_errors++;
    $display("[FAIL] bus answer expected 1 seen 0");
    finish_test;
  endtask
  // bready and rready stay high, so the answer edge is the handshake
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input bit bad = 0);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= {bad, 1'b0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 100);
    if (t == 100) hang;
    chk("bresp", bresp, bad ? `RESP_SLVERR : `RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input bit bad = 0);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= {bad, 1'b0, i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 100);
    if (t == 100) hang;
    chk("rresp", rresp, bad ? `RESP_SLVERR : `RESP_OKAY);
    chk("rdata", rdata, {24'h0, e});
  endtask
  // counts fan-on cycles and rising edges of fan power
  task automatic meas(input int n, output int on, output int rs);
    logic p;
    on = 0;
    rs = 0;
    p = fan_on;
    repeat (n) begin
      @(posedge aclk);
      on += fan_on;
      rs += fan_on & !p;
      p = fan_on;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    int on, rs;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    remote_temp = 8'h10;
    pol = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IDX_PWM_CFG, 8'h20);
    rd(`IDX_SPIN_CFG, 8'h3f);
    rd(`IDX_FREQ, 8'h17);
    rd(`IDX_CFG, 8'h00);
    rd(8'h4a, 8'h00, 1'b1);
    wr(8'h4a, 8'h5a, 1'b1);
    wr(`IDX_SPIN_CFG, 8'hff);
    rd(`IDX_SPIN_CFG, 8'h3f);
    wr(`IDX_SPIN_CFG, 8'h18);
    wr(`IDX_CFG_MIRROR, 8'h84);
    rd(`IDX_CFG, 8'h84);
    repeat (3) @(posedge aclk);
    chk("pin sel", pin_sel, 1);
    for (int m = 0; m < 8; m++) begin
      wr(`IDX_PWM_CFG, {4'h2, m[2], 1'b0, m[1:0]});
      repeat (3) @(posedge aclk);
      chk("tach mode", tach_mode, m[2] ? m[1:0] : 2'h0);
      chk("ffff", ffff, m[2] && m[1:0] != 2'h0);
      chk("smart", smart, m[2] & m[1]);
    end
    // table mode refuses duty and table writes
    wr(`IDX_PWM_CFG, 8'h00);
    wr(`IDX_DUTY, 8'h15);
    wr(8'h50, 8'h00);
    rd(`IDX_DUTY, 8'h00);
    wr(`IDX_PWM_CFG, 8'h20);
    wr(8'h50, 8'h00);
    wr(`IDX_PWM_CFG, 8'h00);
    rd(`IDX_DUTY, 8'h3f);
    // a cooler remote reading no longer exceeds the lowered first entry
    remote_temp <= 8'h00;
    rd(`IDX_DUTY, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_PWM_CFG, {3'h1, k[1], 4'h0});
      wr(`IDX_DUTY, k[0] ? 8'h3f : 8'h00);
      pol <= k[1];
      repeat (4) @(posedge aclk);
      meas(200, on, rs);
      chk("on cycles", on, k[0] ? 200 : 0);
    end
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_PWM_CFG, {4'h2, k == 2, 3'h0});
      pol <= 1'b0;
      wr(`IDX_FREQ, {7'h0, k == 0});
      wr(`IDX_DUTY, 8'h10);
      repeat (40) @(posedge aclk);
      meas(64, on, rs);
      chk("pulses", rs >= (k == 2 ? 3 : 15) && rs <= (k == 2 ? 5 : 17), 1);
    end
    wr(`IDX_PWM_CFG, 8'h20);
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_DUTY, 8'h00);
      wr(`IDX_SPIN_CFG, sc[k]);
      wr(`IDX_DUTY, 8'h01);
      rd(`IDX_DUTY, 8'h00);
      meas(8, on, rs);
      chk("spin on", on, 8);
      repeat (sw[k]) @(posedge aclk);
      rd(`IDX_DUTY, se[k]);
      repeat (1300) @(posedge aclk);
    end
    // spin-up duty codes seen over whole 16-cycle pwm periods
    wr(`IDX_FREQ, 8'h04);
    for (int k = 1; k < 4; k++) begin
      wr(`IDX_DUTY, 8'h00);
      wr(`IDX_SPIN_CFG, {3'h0, k[1:0], 3'h7});
      wr(`IDX_DUTY, 8'h01);
      repeat (2) @(posedge aclk);
      meas(64, on, rs);
      chk("spin level", on, k == 1 ? 40 : k == 2 ? 56 : 64);
      repeat (1300) @(posedge aclk);
    end
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_DUTY, 8'h00);
      wr(`IDX_SPIN_CFG, bc[k]);
      wr(`IDX_DUTY, 8'h01);
      rd(`IDX_DUTY, 8'h01);
    end
    finish_test;
  end
endmodule
